// ---- rtl/tcp_i2c_port.sv ----
// I2C target port of the touch controller: pin engine on the link clock, register access on the main clock.
`timescale 1ns/1ps

// Notes on behaviour
// - Port is a target only; it never generates a start condition.
// - Answers one of two address pairs, write and read forms, chosen at power-on.
// - Start is data falling while clock high; it restarts the byte engine.
// - Matching address byte is acknowledged by pulling data low in ninth clock.
// - Non-matching address gets no acknowledge; port returns to idle.
// - Each byte is eight data bits plus one acknowledge bit from the receiver.
// - Data sampled while clock high; changed only while clock low.
// - Stop is data rising while clock high; port releases bus and idles.
// - Write: write-form address, 16-bit register address, then data bytes.
// - Pointer increments by one after each stored data byte.
// - Burst write runs until the host sends stop.
// - Port sends read bytes; host acknowledges each byte it wants continued.
// - On host not-acknowledge the port releases the data line.
module tcp_i2c_port #(
	parameter logic ALT_INT_LEVEL = 1'b1
) (
	// Clocks and reset
	input  wire logic                   MCLK_I,
	input  wire logic                   RST_N_I,
	input  wire logic                   LCLK_I,
	// Bus pins, open drain
	input  wire logic                   SCL_I,
	output logic                        SCL_O,
	output logic                        SCL_OE_O,
	input  wire logic                   SDA_I,
	output logic                        SDA_O,
	output logic                        SDA_OE_O,
	// Power-on address strap
	input  wire logic                   INT_I,
	// Written-byte stream
	output logic                        WR_VALID_O,
	output tcp_pkg::tcp_wr_word_type    WR_WORD_O,
	input  wire logic                   WR_READY_I,
	// Register read access
	output logic                        RD_REQ_O,
	output logic [15:0]                 RD_ADDR_O,
	input  wire logic [7:0]             RD_DATA_I,
	input  wire logic                   RD_VALID_I
);

	// ------------------------------------------------------------------
	// State of both domains
	// ------------------------------------------------------------------
	typedef struct packed {
		logic                     scl_s1;
		logic                     scl_s2;
		logic                     sda_s1;
		logic                     sda_s2;
		logic                     scl_p;
		logic                     sda_p;
		logic                     alt_s1;
		logic                     alt_s2;
		logic                     ack_s1;
		logic                     ack_s2;
		tcp_pkg::tcp_link_st_type st;
		tcp_pkg::tcp_kind_type    kind;
		logic [3:0]               cnt;
		logic [7:0]               sh;
		logic                     rw;
		logic                     mack;
		logic [15:0]              ptr;
		logic                     req;
		tcp_pkg::tcp_item_type    item;
		logic                     sda_oe;
		logic                     scl_oe;
	} tcp_link_state_type;

	typedef struct packed {
		logic                      req_s1;
		logic                      req_s2;
		logic                      req_seen;
		logic                      ack;
		logic [7:0]                rdata;
		tcp_pkg::tcp_core_st_type  st;
		logic                      push_valid;
		tcp_pkg::tcp_wr_word_type  push_word;
		logic                      rd_req;
		logic [15:0]               rd_addr;
		logic                      int_s1;
		logic                      int_s2;
		logic [1:0]                strap_cnt;
		logic                      alt;
	} tcp_core_state_type;

	tcp_link_state_type l_q;
	tcp_link_state_type l_d;
	tcp_core_state_type c_q;
	tcp_core_state_type c_d;

	logic start_seen;
	logic stop_seen;
	logic scl_rise;
	logic scl_fall;
	logic busy;
	logic fifo_ready;
	logic fifo_empty;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic addr_match(input logic [7:0] b, input logic alt);
		addr_match = b[7:1] == (alt ? tcp_pkg::ADDR_PAIR_ALT : tcp_pkg::ADDR_PAIR_MAIN);
	endfunction

	function automatic tcp_pkg::tcp_item_type read_item(input logic [15:0] a);
		read_item = '{rd: 1'b1, addr: a, data: tcp_pkg::SHIFT_RESET};
	endfunction

	// ------------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------------
	// Open drain: only the enables move, the driven level is always low.
	assign SCL_O    = 1'b0;
	assign SDA_O    = 1'b0;
	assign SCL_OE_O = l_q.scl_oe;
	assign SDA_OE_O = l_q.sda_oe;

	// ------------------------------------------------------------------
	// Link domain
	// ------------------------------------------------------------------
	// Line events read only the second synchroniser stage and its delayed copy.
	always_comb begin
		start_seen = l_q.scl_s2 && l_q.scl_p && l_q.sda_p && !l_q.sda_s2;
		stop_seen  = l_q.scl_s2 && l_q.scl_p && !l_q.sda_p && l_q.sda_s2;
		scl_rise   = l_q.scl_s2 && !l_q.scl_p;
		scl_fall   = !l_q.scl_s2 && l_q.scl_p;
		busy       = l_q.req != l_q.ack_s2;
	end

	always_comb begin
		l_d        = l_q;
		l_d.scl_s1 = SCL_I;
		l_d.scl_s2 = l_q.scl_s1;
		l_d.sda_s1 = SDA_I;
		l_d.sda_s2 = l_q.sda_s1;
		l_d.scl_p  = l_q.scl_s2;
		l_d.sda_p  = l_q.sda_s2;
		l_d.alt_s1 = c_q.alt;
		l_d.alt_s2 = l_q.alt_s1;
		l_d.ack_s1 = c_q.ack;
		l_d.ack_s2 = l_q.ack_s1;
		if (start_seen) begin
			l_d.st     = tcp_pkg::LK_RX;
			l_d.kind   = tcp_pkg::KD_ADDR;
			l_d.cnt    = '0;
			l_d.sda_oe = 1'b0;
		end else if (stop_seen) begin
			l_d.st     = tcp_pkg::LK_IDLE;
			l_d.sda_oe = 1'b0;
		end else begin
			unique case (l_q.st)
				tcp_pkg::LK_IDLE: begin
					l_d.sda_oe = 1'b0;
					l_d.scl_oe = 1'b0;
				end
				tcp_pkg::LK_RX: begin
					if (scl_rise) begin
						l_d.sh  = {l_q.sh[6:0], l_q.sda_s2};
						l_d.cnt = 4'(l_q.cnt + 4'h1);
					end
					// eight bits then hold for acknowledge
					if (scl_fall && l_q.cnt == tcp_pkg::BITS_PER_BYTE) begin
						l_d.st     = tcp_pkg::LK_DONE;
						l_d.scl_oe = 1'b1;
					end
				end
				tcp_pkg::LK_DONE: begin
					// Clock is stretched until the previous word has been taken.
					if (!busy) begin
						l_d.sda_oe = 1'b1;
						l_d.st     = tcp_pkg::LK_RXACK;
						unique case (l_q.kind)
							tcp_pkg::KD_ADDR: begin
								l_d.rw   = l_q.sh[0];
								l_d.kind = tcp_pkg::KD_PHI;
								if (!addr_match(l_q.sh, l_q.alt_s2)) begin
									l_d.sda_oe = 1'b0;
									l_d.st     = tcp_pkg::LK_IDLE;
								end
							end
							tcp_pkg::KD_PHI: begin
								l_d.ptr[15:8] = l_q.sh;
								l_d.kind      = tcp_pkg::KD_PLO;
							end
							tcp_pkg::KD_PLO: begin
								l_d.ptr[7:0] = l_q.sh;
								l_d.kind     = tcp_pkg::KD_DATA;
							end
							tcp_pkg::KD_DATA: begin
								l_d.item = '{rd: 1'b0, addr: l_q.ptr, data: l_q.sh};
								l_d.req  = !l_q.req;
								l_d.ptr  = 16'(l_q.ptr + 16'h0001);
							end
						endcase
					end
				end
				tcp_pkg::LK_RXACK: begin
					// Data settles one link cycle before the clock is let go, so it never moves as SCL rises.
					l_d.scl_oe = 1'b0;
					if (scl_fall) begin
						l_d.sda_oe = 1'b0;
						l_d.cnt    = '0;
						if (l_q.rw) begin
							l_d.item   = read_item(l_q.ptr);
							l_d.req    = !l_q.req;
							l_d.scl_oe = 1'b1;
							l_d.st     = tcp_pkg::LK_LOAD;
						end else begin
							l_d.st = tcp_pkg::LK_RX;
						end
					end
				end
				tcp_pkg::LK_LOAD: begin
					if (!busy) begin
						l_d.sh     = c_q.rdata;
						l_d.sda_oe = !c_q.rdata[7];
						l_d.cnt    = '0;
						l_d.ptr    = 16'(l_q.ptr + 16'h0001);
						l_d.st     = tcp_pkg::LK_TX;
					end
				end
				tcp_pkg::LK_TX: begin
					l_d.scl_oe = 1'b0;
					if (scl_rise) begin
						l_d.cnt = 4'(l_q.cnt + 4'h1);
					end
					if (scl_fall) begin
						if (l_q.cnt == tcp_pkg::BITS_PER_BYTE) begin
							l_d.sda_oe = 1'b0;
							l_d.st     = tcp_pkg::LK_TXACK;
						end else begin
							l_d.sh     = {l_q.sh[6:0], 1'b0};
							l_d.sda_oe = !l_q.sh[6];
						end
					end
				end
				tcp_pkg::LK_TXACK: begin
					if (scl_rise) begin
						l_d.mack = !l_q.sda_s2;
					end
					if (scl_fall) begin
						if (l_q.mack) begin
							l_d.item   = read_item(l_q.ptr);
							l_d.req    = !l_q.req;
							l_d.scl_oe = 1'b1;
							l_d.st     = tcp_pkg::LK_LOAD;
						end else begin
							l_d.sda_oe = 1'b0;
							l_d.st     = tcp_pkg::LK_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge LCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			l_q        <= '0;
			l_q.scl_s1 <= 1'b1;
			l_q.scl_s2 <= 1'b1;
			l_q.sda_s1 <= 1'b1;
			l_q.sda_s2 <= 1'b1;
			l_q.scl_p  <= 1'b1;
			l_q.sda_p  <= 1'b1;
			l_q.st     <= tcp_pkg::LK_IDLE;
			l_q.kind   <= tcp_pkg::KD_ADDR;
			l_q.ptr    <= tcp_pkg::PTR_RESET;
		end else begin
			l_q <= l_d;
		end
	end

	// ------------------------------------------------------------------
	// Main-clock domain
	// ------------------------------------------------------------------
	always_comb begin
		c_d        = c_q;
		c_d.req_s1 = l_q.req;
		c_d.req_s2 = c_q.req_s1;
		c_d.int_s1 = INT_I;
		c_d.int_s2 = c_q.int_s1;
		c_d.rd_req = 1'b0;
		if (c_q.strap_cnt != tcp_pkg::STRAP_CAPTURE) begin
			c_d.strap_cnt = 2'(c_q.strap_cnt + 2'h1);
			c_d.alt       = c_q.int_s2 == ALT_INT_LEVEL;
		end
		unique case (c_q.st)
			tcp_pkg::CR_IDLE: begin
				// The link item is held stable until our answer toggles back.
				if (c_q.req_s2 != c_q.req_seen) begin
					c_d.req_seen = c_q.req_s2;
					if (l_q.item.rd) begin
						c_d.st = tcp_pkg::CR_DRAIN;
					end else begin
						c_d.push_valid = 1'b1;
						c_d.push_word  = '{addr: l_q.item.addr, data: l_q.item.data};
						c_d.st         = tcp_pkg::CR_PUSH;
					end
				end
			end
			tcp_pkg::CR_PUSH: begin
				if (fifo_ready) begin
					c_d.push_valid = 1'b0;
					c_d.ack        = !c_q.ack;
					c_d.st         = tcp_pkg::CR_IDLE;
				end
			end
			tcp_pkg::CR_DRAIN: begin
				// Reads wait behind pending writes so a write-then-read sees new data.
				if (fifo_empty) begin
					c_d.rd_req  = 1'b1;
					c_d.rd_addr = l_q.item.addr;
					c_d.st      = tcp_pkg::CR_WAIT;
				end
			end
			tcp_pkg::CR_WAIT: begin
				if (RD_VALID_I) begin
					c_d.rdata = RD_DATA_I;
					c_d.ack   = !c_q.ack;
					c_d.st    = tcp_pkg::CR_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			c_q    <= '0;
			c_q.st <= tcp_pkg::CR_IDLE;
		end else begin
			c_q <= c_d;
		end
	end

	assign RD_REQ_O  = c_q.rd_req;
	assign RD_ADDR_O = c_q.rd_addr;

	// ------------------------------------------------------------------
	// Write buffer
	// ------------------------------------------------------------------
	tcp_fifo #(
		.WIDTH (tcp_pkg::FIFO_WIDTH),
		.DEPTH (tcp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i       (MCLK_I),
		.rst_n_i     (RST_N_I),
		.in_valid_i  (c_q.push_valid),
		.in_ready_o  (fifo_ready),
		.in_data_i   (c_q.push_word),
		.out_valid_o (WR_VALID_O),
		.out_ready_i (WR_READY_I),
		.out_data_o  (WR_WORD_O),
		.empty_o     (fifo_empty)
	);

endmodule

// ---- common/tcp_pkg.sv ----
// Shared constants and types of the touch controller I2C target port.
package tcp_pkg;

	// ------------------------------------------------------------------
	// Target addresses (7-bit form, read/write bit excluded)
	// ------------------------------------------------------------------
	localparam logic [6:0] ADDR_PAIR_MAIN = 7'h5D;
	localparam logic [6:0] ADDR_PAIR_ALT  = 7'h14;

	// ------------------------------------------------------------------
	// Byte framing, buffering and strap capture
	// ------------------------------------------------------------------
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int         FIFO_DEPTH    = 32;
	localparam int         FIFO_WIDTH    = 24;
	localparam logic [1:0] STRAP_CAPTURE = 2'h3;

	// ------------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------------
	localparam logic [15:0] PTR_RESET   = 16'h0000;
	localparam logic [7:0]  SHIFT_RESET = 8'h00;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} tcp_wr_word_type;

	typedef struct packed {
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  data;
	} tcp_item_type;

	// ------------------------------------------------------------------
	// State machines
	// ------------------------------------------------------------------
	typedef enum logic [6:0] {
		LK_IDLE  = 7'h01,
		LK_RX    = 7'h02,
		LK_DONE  = 7'h04,
		LK_RXACK = 7'h08,
		LK_LOAD  = 7'h10,
		LK_TX    = 7'h20,
		LK_TXACK = 7'h40
	} tcp_link_st_type;

	typedef enum logic [3:0] {
		KD_ADDR = 4'h1,
		KD_PHI  = 4'h2,
		KD_PLO  = 4'h4,
		KD_DATA = 4'h8
	} tcp_kind_type;

	typedef enum logic [3:0] {
		CR_IDLE  = 4'h1,
		CR_PUSH  = 4'h2,
		CR_DRAIN = 4'h4,
		CR_WAIT  = 4'h8
	} tcp_core_st_type;

endpackage

// ---- rtl/tcp_fifo.sv ----
// Synchronous FIFO with registered read data, used for the written-byte stream.
`timescale 1ns/1ps
module tcp_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  empty_o
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               rd_ptr;
		logic [PW-1:0]               wr_ptr;
		logic [CW-1:0]               count;
		logic                        out_valid;
		logic [WIDTH-1:0]            out_data;
	} tcp_fifo_state_type;

	tcp_fifo_state_type s_q;
	tcp_fifo_state_type s_d;
	logic               push;
	logic               pop;

	assign in_ready_o  = s_q.count != CW'(DEPTH);
	assign out_valid_o = s_q.out_valid;
	assign out_data_o  = s_q.out_data;
	assign empty_o     = (s_q.count == '0) && !s_q.out_valid;

	always_comb begin
		s_d  = s_q;
		push = in_valid_i && in_ready_o;
		pop  = (s_q.count != '0) && (!s_q.out_valid || out_ready_i);
		if (out_ready_i) begin
			s_d.out_valid = 1'b0;
		end
		if (push) begin
			s_d.mem[s_q.wr_ptr] = in_data_i;
			s_d.wr_ptr          = PW'(s_q.wr_ptr + 1'b1);
		end
		if (pop) begin
			s_d.out_data  = s_q.mem[s_q.rd_ptr];
			s_d.out_valid = 1'b1;
			s_d.rd_ptr    = PW'(s_q.rd_ptr + 1'b1);
		end
		s_d.count = CW'(s_q.count + CW'(push) - CW'(pop));
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

// ---- tb/tcp_i2c_port_monitor.sv ----
// Port-level checks of the touch controller I2C target port.
`timescale 1ns/1ps
module tcp_i2c_port_monitor (
	// Clocks and reset
	input wire logic                     MCLK_I,
	input wire logic                     RST_N_I,
	input wire logic                     LCLK_I,
	// Bus pins
	input wire logic                     SCL_I,
	input wire logic                     SCL_OE_O,
	input wire logic                     SDA_I,
	input wire logic                     SDA_OE_O,
	// Register side
	input wire logic                     WR_VALID_O,
	input wire tcp_pkg::tcp_wr_word_type WR_WORD_O,
	input wire logic                     WR_READY_I,
	input wire logic                     RD_REQ_O,
	input wire logic [15:0]              RD_ADDR_O
);
	// ----------------------------------------------------------------
	// Link side
	// ----------------------------------------------------------------
	property p_no_start;
		@(posedge LCLK_I) disable iff (!RST_N_I) $rose(SDA_OE_O) |-> !SCL_I;
	endproperty
	a_no_start: assert property (p_no_start) else $error("data pulled low while clock high");
	property p_release_low;
		@(posedge LCLK_I) disable iff (!RST_N_I) $fell(SDA_OE_O) |-> !SCL_I;
	endproperty
	a_release_low: assert property (p_release_low) else $error("data released while clock high");
	property p_stretch_low;
		@(posedge LCLK_I) disable iff (!RST_N_I) $rose(SCL_OE_O) |-> !SCL_I;
	endproperty
	a_stretch_low: assert property (p_stretch_low) else $error("clock pulled while high");
	property p_stop_idle;
		@(posedge LCLK_I) disable iff (!RST_N_I)
			SCL_I && $past(SCL_I) && SDA_I && !$past(SDA_I) |-> (!SDA_OE_O && !SCL_OE_O) [*8];
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("bus not released after stop");
	// ----------------------------------------------------------------
	// Register side
	// ----------------------------------------------------------------
	property p_wr_hold;
		@(posedge MCLK_I) disable iff (!RST_N_I) WR_VALID_O && !WR_READY_I |=> WR_VALID_O && $stable(WR_WORD_O);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("written word dropped before taken");
	property p_rd_pulse;
		@(posedge MCLK_I) disable iff (!RST_N_I) RD_REQ_O |=> !RD_REQ_O;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read request longer than one cycle");
	property p_rd_drained;
		@(posedge MCLK_I) disable iff (!RST_N_I) RD_REQ_O |-> !WR_VALID_O;
	endproperty
	a_rd_drained: assert property (p_rd_drained) else $error("read issued before writes drained");
	property p_rd_addr;
		@(posedge MCLK_I) disable iff (!RST_N_I) $changed(RD_ADDR_O) |-> RD_REQ_O;
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("read address moved without request");
	c_read: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) RD_REQ_O);
	c_take: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) WR_VALID_O && WR_READY_I);
	c_stretch: cover property (@(posedge LCLK_I) disable iff (!RST_N_I) $rose(SCL_OE_O));
endmodule

bind tcp_i2c_port tcp_i2c_port_monitor u_monitor (
	.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .LCLK_I(LCLK_I), .SCL_I(SCL_I), .SCL_OE_O(SCL_OE_O),
	.SDA_I(SDA_I), .SDA_OE_O(SDA_OE_O), .WR_VALID_O(WR_VALID_O), .WR_WORD_O(WR_WORD_O),
	.WR_READY_I(WR_READY_I), .RD_REQ_O(RD_REQ_O), .RD_ADDR_O(RD_ADDR_O)
);

// ---- tb/tcp_host_model.sv ----
// Behavioural bus host driving the open-drain clock and data lines.
`timescale 1ns/1ps
module tcp_host_model #(
	parameter int QUARTER_NS = 650
) (
	// Wire levels
	input  wire logic scl_i,
	input  wire logic sda_i,
	// Pull-low enables
	output logic      scl_low_o,
	output logic      sda_low_o
);
	// ----------------------------------------------------------------
	// Bus phases
	// ----------------------------------------------------------------
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	// one bit time: the wait honours clock stretching, so 2.6 us is a floor.
	task automatic rise_hold(output logic s);
		#QUARTER_NS;
		scl_low_o = 1'b0;
		while (scl_i !== 1'b1) #10;
		#QUARTER_NS;
		s = sda_i;
		#QUARTER_NS;
	endtask
	task automatic pulse(output logic s);
		rise_hold(s);
		scl_low_o = 1'b1;
		#QUARTER_NS;
	endtask
	task automatic start();
		logic s;
		sda_low_o = 1'b0;
		rise_hold(s);
		sda_low_o = 1'b1;
		#QUARTER_NS;
		scl_low_o = 1'b1;
		#QUARTER_NS;
	endtask
	task automatic stop();
		logic s;
		sda_low_o = 1'b1;
		rise_hold(s);
		sda_low_o = 1'b0;
		#QUARTER_NS;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low_o = !b[i];
			pulse(ack);
		end
		sda_low_o = 1'b0;
		pulse(ack);
	endtask
	task automatic rbyte(input logic last, output logic [7:0] b);
		logic s;
		sda_low_o = 1'b0;
		for (int i = 7; i >= 0; i--) pulse(b[i]);
		sda_low_o = !last;
		pulse(s);
		sda_low_o = 1'b0;
	endtask
endmodule

// ---- tb/tcp_i2c_port_test.sv ----
// Self-checking bench of the touch controller I2C target port.
`timescale 1ns/1ps
module tcp_i2c_port_test;
	localparam int         LIMIT = 100000;
	localparam logic [6:0] MAIN  = tcp_pkg::ADDR_PAIR_MAIN;
	localparam logic [6:0] ALT   = tcp_pkg::ADDR_PAIR_ALT;
	logic                     mclk, lclk, rst_n, int_lvl, wr_ready, rd_valid, stall;
	logic                     scl_oe, sda_oe, scl_o, sda_o, h_scl, h_sda, wr_valid, rd_req;
	logic [7:0]               rd_data;
	logic [15:0]              rd_addr_o, ptr, rd_exp, rd_addr;
	logic [7:0]               regs [logic [15:0]];
	logic [7:0]               model [logic [15:0]];
	logic [23:0]              exp_wr [$];
	tcp_pkg::tcp_wr_word_type wr_word;
	int                       miscompares, checks, cycles, rd_wait;
	wire logic                scl = !(h_scl || (scl_oe && !scl_o));
	wire logic                sda = !(h_sda || (sda_oe && !sda_o));

	tcp_i2c_port uut (
		.MCLK_I(mclk), .RST_N_I(rst_n), .LCLK_I(lclk), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_O(scl_oe),
		.SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .INT_I(int_lvl), .WR_VALID_O(wr_valid),
		.WR_WORD_O(wr_word), .WR_READY_I(wr_ready), .RD_REQ_O(rd_req), .RD_ADDR_O(rd_addr_o),
		.RD_DATA_I(rd_data), .RD_VALID_I(rd_valid)
	);
	tcp_host_model host (.scl_i(scl), .sda_i(sda), .scl_low_o(h_scl), .sda_low_o(h_sda));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #15 lclk = ~lclk;
	end
	// ----------------------------------------------------------------
	// Comparison and register-side model
	// ----------------------------------------------------------------
	function automatic logic [7:0] init_val(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction
	function automatic logic [7:0] expect_at(input logic [15:0] a);
		return model.exists(a) ? model[a] : init_val(a);
	endfunction
	task automatic cmp_word(input string what, input logic [23:0] exp, input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_word(what, {16'h0000, exp}, {16'h0000, got});
	endtask
	task automatic cmp_bit(input string what, input logic exp, input logic got);
		cmp_word(what, {23'h000000, exp}, {23'h000000, got});
	endtask
	task automatic test_done();
		if (miscompares == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			test_done();
		end
	end
	always @(posedge mclk) begin
		if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
			cmp_word("written word", (exp_wr.size() != 0) ? exp_wr.pop_front() : 24'hFFFFFF, wr_word);
			regs[wr_word.addr] = wr_word.data;
		end
		if (rd_req === 1'b1) begin
			cmp_word("read address", {8'h00, rd_exp}, {8'h00, rd_addr_o});
			rd_exp = rd_exp + 16'h0001;
		end
	end
	// Idle read data is scrambled so that a stale byte never passes.
	always @(negedge mclk) begin
		if (rd_req === 1'b1) begin
			rd_wait = $urandom_range(1, 6);
			rd_addr = rd_addr_o;
		end else if (rd_wait > 0) begin
			rd_wait = rd_wait - 1;
		end
		wr_ready <= stall ? 1'b0 : ($urandom_range(0, 3) != 0);
		rd_valid <= (rd_wait == 1);
		rd_data <= (rd_wait == 1) ? (regs.exists(rd_addr) ? regs[rd_addr] : init_val(rd_addr)) : 8'($urandom());
	end
	// ----------------------------------------------------------------
	// Transactions
	// ----------------------------------------------------------------
	// strap level held across reset release.
	task automatic do_reset(input logic lvl);
		@(negedge mclk);
		rst_n = 1'b0;
		int_lvl = lvl;
		repeat (8) @(negedge mclk);
		rst_n = 1'b1;
		ptr = tcp_pkg::PTR_RESET;
		rd_exp = ptr;
		repeat (20) @(negedge mclk);
		cmp_bit("data drive after reset", 1'b0, sda_oe);
		cmp_bit("write valid after reset", 1'b0, wr_valid);
	endtask
	task automatic refuse(input logic [6:0] a);
		logic ack;
		host.start();
		host.wbyte({a, 1'b0}, ack);
		cmp_bit("foreign address ack", 1'b1, ack);
		host.stop();
	endtask
	task automatic set_ptr(input logic [6:0] a, input logic [15:0] p);
		logic ack;
		host.start();
		host.wbyte({a, 1'b0}, ack);
		cmp_bit("address ack", 1'b0, ack);
		host.wbyte(p[15:8], ack);
		cmp_bit("pointer high ack", 1'b0, ack);
		host.wbyte(p[7:0], ack);
		cmp_bit("pointer low ack", 1'b0, ack);
		ptr = p;
		rd_exp = p;
	endtask
	task automatic write_burst(input logic [6:0] a, input logic [15:0] p, input int n);
		logic       ack;
		logic [7:0] d;
		set_ptr(a, p);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom());
			exp_wr.push_back({ptr, d});
			model[ptr] = d;
			host.wbyte(d, ack);
			cmp_bit("data ack", 1'b0, ack);
			ptr = ptr + 16'h0001;
		end
		rd_exp = ptr;
		host.stop();
	endtask
	// a start without a stop before it acts as the repeated start.
	task automatic read_burst(input logic [6:0] a, input int n);
		logic       ack;
		logic [7:0] d;
		host.start();
		host.wbyte({a, 1'b1}, ack);
		cmp_bit("read address ack", 1'b0, ack);
		for (int i = 0; i < n; i++) begin
			host.rbyte(i == n - 1, d);
			cmp_byte("read data", expect_at(ptr), d);
			ptr = ptr + 16'h0001;
		end
		cmp_bit("data drive after nack", 1'b0, sda_oe);
		cmp_word("fetch count", {8'h00, ptr}, {8'h00, rd_exp});
		host.stop();
	endtask
	task automatic wait_full();
		int run;
		run = 0;
		while (run < 300) begin
			@(posedge mclk);
			run = (scl_oe === 1'b1) ? run + 1 : 0;
		end
		cmp_bit("full buffer holds word", 1'b1, wr_valid);
		stall = 1'b0;
	endtask
	initial begin
		rst_n = 1'b0;
		int_lvl = 1'b0;
		wr_ready = 1'b0;
		rd_valid = 1'b0;
		rd_data = 8'h00;
		stall = 1'b0;
		void'($urandom(32'h3BC7C6B6));
		do_reset(!uut.ALT_INT_LEVEL);
		refuse(7'h33);
		refuse(ALT);
		stall = 1'b1;
		fork
			write_burst(MAIN, 16'hFFF0, 35);
			wait_full();
		join
		for (int i = 0; i < 2000 && exp_wr.size() != 0; i++) @(posedge mclk);
		@(negedge mclk);
		cmp_bit("buffer drained", 1'b1, exp_wr.size() == 0);
		set_ptr(MAIN, 16'hFFF8);
		read_burst(MAIN, 4);
		read_burst(MAIN, 3);
		do_reset(uut.ALT_INT_LEVEL);
		refuse(MAIN);
		read_burst(ALT, 1);
		write_burst(ALT, 16'h0200, 2);
		read_burst(ALT, 2);
		test_done();
	end
endmodule
